/* logic/serial_async_control.sv */
// Purpose: Asynchronous serial interface with its control, flags and line logic.
// Assumes: rx_pin is synchronous to mclk; bit time is (baud register + 1) cycles.
// Notes:   Status flags clear by a status read followed by a data access.

`timescale 1ns/100ps

// Operation
// - Invert every transmitted level when invert set.
// - Length bit picks nine or eight bits.
// - Wake bit picks address mark or idle.
// - Idle count starts after stop or start.
// - Parity generated and checked in MSB.
// - Frames are ten or eleven bits long.
// - Enabled transmitter-empty raises transmitter interrupt while unit enable is on.
// - Enabled transmission-complete raises transmitter interrupt while unit enable is on.
// - Enabled receiver-full raises receiver interrupt.
// - Enabled idle flag raises receiver interrupt.
// - Transmitter enable sends a preamble of ones.
// - Disabling transmitter finishes character, then idles high.
// - Toggling transmitter enable queues one idle character.
// - Receiver disable stops reception, keeps flags.
// - Standby masks receive interrupts; wakeup clears it.
// - Break then one; held break repeats.
// - Received ninth bit captured; reset keeps it.
// - Transmit ninth bit loaded with data.
// - Enabled overrun raises error interrupt.
// - Unit enable off sets empty, done flags.
module serial_async_control
  import serial_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line.
  output logic             tx_pin,
  input  wire logic        rx_pin,
  // Interrupt requests.
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);

  // ***************************************************************
  // Registers and flags.
  // ***************************************************************
  logic [7:0]  fmt_r;
  logic [7:0]  ena_r;
  logic        ovr_en_r;
  logic [7:0]  baud_r;
  logic        tx_ninth_bit;
  logic        rx_ninth_bit;
  logic [7:0]  data_buffer_reg;
  logic [7:0]  rx_buf_r;
  logic        tx_empty_flag;
  logic        tx_done_flag;
  logic        rx_full_flag;
  logic        idle_flag_r;
  logic        overrun_r;
  logic        par_err_r;
  logic        te_arm_r;
  logic [3:0]  rx_arm_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        tx_pin_r;
  logic        tx_irq_r;
  logic        rx_irq_r;
  logic        err_irq_r;

  tx_state_t   tx_state;
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_bits_r;
  logic [7:0]  tx_cnt_r;
  logic        pre_pend_r;
  logic        post_brk_r;

  rx_state_t   rx_state;
  logic [10:0] rx_sh_r;
  logic [3:0]  rx_bits_r;
  logic [7:0]  rx_cnt_r;
  logic [3:0]  idle_cnt_r;
  logic        idle_seen_r;

  // ***************************************************************
  // Decoded controls.
  // ***************************************************************
  logic serial_unit_on;
  logic transmit_invert;
  logic char9;
  logic wake_on_mark;
  logic idle_count_origin;
  logic parity_on;
  logic parity_odd_sel;
  logic tx_on;
  logic rx_on;
  logic rx_standby;
  logic break_send;
  logic [3:0] frame_len;

  assign serial_unit_on    = fmt_r[FMT_UNIT_ON];
  assign transmit_invert   = fmt_r[FMT_INVERT];
  assign char9             = fmt_r[FMT_CHAR9];
  assign wake_on_mark      = fmt_r[FMT_WAKE_MK];
  assign idle_count_origin = fmt_r[FMT_IDLE_OR];
  assign parity_on         = fmt_r[FMT_PAR_ON];
  assign parity_odd_sel    = fmt_r[FMT_PAR_ODD];
  assign tx_on             = ena_r[ENA_TX_ON];
  assign rx_on             = ena_r[ENA_RX_ON];
  assign rx_standby        = ena_r[ENA_STBY];
  assign break_send        = ena_r[ENA_BREAK];
  assign frame_len         = char9 ? LEN9 : LEN8;

  // ***************************************************************
  // APB access decode.
  // ***************************************************************
  logic       setup;
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic [7:0] rd_val;
  logic [7:0] status;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready_r & pwrite;
  assign rd_acc = psel & penable & pready_r & ~pwrite;
  assign mapped = (paddr == FMT_OFF) | (paddr == ENA_OFF) | (paddr == NTH_OFF) |
                  (paddr == DATA_OFF) | (paddr == STAT_OFF) | (paddr == BAUD_OFF);

  always_comb begin
    status = 8'h00;
    status[ST_TX_EMPTY] = tx_empty_flag;
    status[ST_TX_DONE]  = tx_done_flag;
    status[ST_RX_FULL]  = rx_full_flag;
    status[ST_IDLE]     = idle_flag_r;
    status[ST_OVERRUN]  = overrun_r;
    status[ST_PAR_ERR]  = par_err_r;
    rd_val = 8'h00;
    case (paddr)
      FMT_OFF:  rd_val = fmt_r;
      ENA_OFF:  rd_val = ena_r;
      NTH_OFF: begin
        rd_val[NTH_RX9]    = rx_ninth_bit;
        rd_val[NTH_TX9]    = tx_ninth_bit;
        rd_val[NTH_OVR_IE] = ovr_en_r;
      end
      DATA_OFF: rd_val = rx_buf_r;
      STAT_OFF: rd_val = status;
      BAUD_OFF: rd_val = baud_r;
      default:  rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      if (setup) begin
        prdata_r <= {24'h00_0000, rd_val};
      end
    end
  end

  // ***************************************************************
  // Transmitter.
  // ***************************************************************
  logic        tx_idle;
  logic        go_brk;
  logic        go_post;
  logic        go_pre;
  logic        go_data;
  logic        tx_start;
  logic [8:0]  tx_pay;
  logic [10:0] tx_frame;

  assign tx_idle  = (tx_state == TX_IDLE) & serial_unit_on & tx_on;
  assign go_brk   = tx_idle & break_send;
  assign go_post  = tx_idle & ~break_send & post_brk_r;
  assign go_pre   = tx_idle & ~break_send & ~post_brk_r & pre_pend_r;
  assign go_data  = tx_idle & ~break_send & ~post_brk_r & ~pre_pend_r & ~tx_empty_flag;
  assign tx_start = go_brk | go_post | go_pre | go_data;

  always_comb begin
    if (char9) begin
      tx_pay = {parity_on ? (^data_buffer_reg ^ parity_odd_sel) : tx_ninth_bit,
                data_buffer_reg};
      tx_frame = {1'b1, tx_pay, 1'b0};
    end else begin
      tx_pay = {1'b1, parity_on ? (^data_buffer_reg[6:0] ^ parity_odd_sel)
                                : data_buffer_reg[7], data_buffer_reg[6:0]};
      tx_frame = {2'b11, tx_pay[7:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state  <= TX_IDLE;
      tx_sh_r   <= ALL_ONES;
      tx_bits_r <= 4'h0;
      tx_cnt_r  <= 8'h00;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_start) begin
            tx_state <= TX_SHIFT;
            tx_cnt_r <= baud_r;
            if (go_brk) begin
              tx_sh_r   <= ALL_ZERO;
              tx_bits_r <= frame_len;
            end else if (go_post) begin
              tx_sh_r   <= ALL_ONES;
              tx_bits_r <= 4'h1;
            end else if (go_pre) begin
              tx_sh_r   <= ALL_ONES;
              tx_bits_r <= frame_len;
            end else begin
              tx_sh_r   <= tx_frame;
              tx_bits_r <= frame_len;
            end
          end
        end
        TX_SHIFT: begin
          if (!serial_unit_on) begin
            tx_state <= TX_IDLE;
          end else if (tx_cnt_r == 8'h00) begin
            tx_cnt_r  <= baud_r;
            tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
            tx_bits_r <= 4'(tx_bits_r - 4'h1);
            if (tx_bits_r == 4'h1 && break_send && tx_on) begin
              tx_sh_r   <= ALL_ZERO;
              tx_bits_r <= frame_len;
            end else if (tx_bits_r == 4'h1) begin
              tx_state <= TX_IDLE;
            end
          end else begin
            tx_cnt_r <= 8'(tx_cnt_r - 8'h01);
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_pend_r <= 1'b0;
      post_brk_r <= 1'b0;
    end else begin
      if (wr_acc && paddr == ENA_OFF && pwdata[ENA_TX_ON] && !tx_on) begin
        pre_pend_r <= 1'b1;
      end else if (go_pre) begin
        pre_pend_r <= 1'b0;
      end
      if (go_brk) begin
        post_brk_r <= 1'b1;
      end else if (go_post) begin
        post_brk_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_pin_r <= 1'b1;
    end else begin
      tx_pin_r <= ((tx_state == TX_SHIFT) ? tx_sh_r[0] : 1'b1) ^ transmit_invert;
    end
  end

  // ***************************************************************
  // Receiver.
  // ***************************************************************
  logic        rx_act;
  logic        rx_tick;
  logic        rx_done;
  logic        s_bit;
  logic [10:0] rx_new;
  logic        rx_msb;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        idle_hit;
  logic        mark_wake;
  logic        idle_wake;
  logic        deliver;

  assign rx_act    = serial_unit_on & rx_on;
  assign rx_tick   = rx_act & (rx_cnt_r == 8'h00);
  assign s_bit     = rx_pin;
  assign rx_new    = {s_bit, rx_sh_r[10:1]};
  assign rx_done   = (rx_state == RX_FRAME) & rx_tick & (rx_bits_r == 4'h1);
  assign rx_msb    = rx_new[9];
  assign rx_data   = char9 ? rx_new[8:1] : rx_new[9:2];
  assign rx_perr   = parity_on & ((char9 ? ^rx_new[9:1] : ^rx_new[9:2]) != parity_odd_sel);
  assign idle_hit  = (rx_state == RX_IDLE) & rx_tick & s_bit &
                     (4'(idle_cnt_r + 4'h1) == frame_len);
  assign mark_wake = rx_done & rx_standby & wake_on_mark & rx_msb;
  assign idle_wake = idle_hit & rx_standby & ~wake_on_mark;
  assign deliver   = rx_done & (~rx_standby | mark_wake);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state   <= RX_IDLE;
      rx_sh_r    <= ALL_ZERO;
      rx_bits_r  <= 4'h0;
      rx_cnt_r   <= 8'h00;
      idle_cnt_r <= 4'h0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (!rx_act) begin
            idle_cnt_r <= 4'h0;
            rx_cnt_r   <= baud_r;
          end else if (!s_bit) begin
            rx_state   <= RX_FRAME;
            rx_cnt_r   <= baud_r >> 1;
            rx_bits_r  <= frame_len;
            idle_cnt_r <= 4'h0;
          end else if (rx_tick) begin
            rx_cnt_r <= baud_r;
            if (idle_cnt_r != frame_len) begin
              idle_cnt_r <= 4'(idle_cnt_r + 4'h1);
            end
          end else begin
            rx_cnt_r <= 8'(rx_cnt_r - 8'h01);
          end
        end
        RX_FRAME: begin
          if (!rx_act) begin
            rx_state <= RX_IDLE;
          end else if (rx_tick) begin
            rx_cnt_r  <= baud_r;
            rx_sh_r   <= rx_new;
            rx_bits_r <= 4'(rx_bits_r - 4'h1);
            if (rx_bits_r == frame_len && s_bit) begin
              rx_state <= RX_IDLE;
            end else if (rx_bits_r == 4'h1) begin
              rx_state <= RX_IDLE;
            end
            if (idle_count_origin || rx_bits_r == frame_len || !s_bit) begin
              idle_cnt_r <= 4'h0;
            end else begin
              idle_cnt_r <= 4'(idle_cnt_r + 4'h1);
            end
          end else begin
            rx_cnt_r <= 8'(rx_cnt_r - 8'h01);
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (deliver && !rx_full_flag) begin
      rx_buf_r     <= rx_data;
      rx_ninth_bit <= rx_new[9];
    end
  end

  // ***************************************************************
  // Register writes.
  // ***************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_r    <= REG_RST;
      ena_r    <= REG_RST;
      ovr_en_r <= 1'b0;
      baud_r   <= BAUD_RST;
    end else begin
      if (wr_acc && paddr == FMT_OFF) begin
        fmt_r <= pwdata[7:0] & FMT_MASK;
      end
      if (wr_acc && paddr == ENA_OFF) begin
        ena_r <= pwdata[7:0];
      end else if (mark_wake || idle_wake) begin
        ena_r[ENA_STBY] <= 1'b0;
      end
      if (wr_acc && paddr == NTH_OFF) begin
        ovr_en_r <= pwdata[NTH_OVR_IE];
      end
      if (wr_acc && paddr == BAUD_OFF) begin
        baud_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_acc && paddr == NTH_OFF) begin
      tx_ninth_bit <= pwdata[NTH_TX9];
    end
    if (wr_acc && paddr == DATA_OFF) begin
      data_buffer_reg <= pwdata[7:0];
    end
  end

  // ***************************************************************
  // Status flags.
  // ***************************************************************
  logic tx_clr;
  logic rx_clr;

  assign tx_clr = wr_acc & (paddr == DATA_OFF) & te_arm_r;
  assign rx_clr = rd_acc & (paddr == DATA_OFF);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      te_arm_r <= 1'b0;
      rx_arm_r <= 4'h0;
    end else begin
      if (rd_acc && paddr == STAT_OFF) begin
        te_arm_r <= prdata_r[ST_TX_EMPTY];
        rx_arm_r <= {prdata_r[ST_RX_FULL], prdata_r[ST_IDLE],
                     prdata_r[ST_OVERRUN], prdata_r[ST_PAR_ERR]};
      end else begin
        if (wr_acc && paddr == DATA_OFF) begin
          te_arm_r <= 1'b0;
        end
        if (rx_clr) begin
          rx_arm_r <= 4'h0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_empty_flag <= 1'b1;
      tx_done_flag  <= 1'b1;
    end else begin
      if (!serial_unit_on || go_data) begin
        tx_empty_flag <= 1'b1;
      end else if (tx_clr) begin
        tx_empty_flag <= 1'b0;
      end
      tx_done_flag <= ~serial_unit_on |
                      ((tx_state == TX_IDLE) & ~tx_start & tx_empty_flag & ~tx_clr);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_full_flag <= 1'b0;
      idle_flag_r  <= 1'b0;
      overrun_r    <= 1'b0;
      par_err_r    <= 1'b0;
      idle_seen_r  <= 1'b0;
    end else begin
      if (deliver && !rx_full_flag) begin
        rx_full_flag <= 1'b1;
      end else if (rx_clr && rx_arm_r[3]) begin
        rx_full_flag <= 1'b0;
      end
      if (deliver && rx_full_flag) begin
        overrun_r <= 1'b1;
      end else if (rx_clr && rx_arm_r[1]) begin
        overrun_r <= 1'b0;
      end
      if (deliver && !rx_full_flag && rx_perr) begin
        par_err_r <= 1'b1;
      end else if (rx_clr && rx_arm_r[0]) begin
        par_err_r <= 1'b0;
      end
      if (idle_hit && !rx_standby && idle_seen_r) begin
        idle_flag_r <= 1'b1;
      end else if (rx_clr && rx_arm_r[2]) begin
        idle_flag_r <= 1'b0;
      end
      if (deliver && !rx_full_flag) begin
        idle_seen_r <= 1'b1;
      end else if (idle_hit && !rx_standby) begin
        idle_seen_r <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Interrupt requests.
  // ***************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_irq_r  <= 1'b0;
      rx_irq_r  <= 1'b0;
      err_irq_r <= 1'b0;
    end else begin
      tx_irq_r  <= serial_unit_on &
                   ((tx_empty_flag & ena_r[ENA_TXE_IE]) |
                    (tx_done_flag & ena_r[ENA_TXD_IE]));
      rx_irq_r  <= ~rx_standby &
                   ((rx_full_flag & ena_r[ENA_RXF_IE]) |
                    (idle_flag_r & ena_r[ENA_IDL_IE]));
      err_irq_r <= overrun_r & ovr_en_r;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign tx_pin  = tx_pin_r;
  assign tx_irq  = tx_irq_r;
  assign rx_irq  = rx_irq_r;
  assign err_irq = err_irq_r;

endmodule

/* logic/serial_pkg.sv */
// Purpose: Shared constants and types of the asynchronous serial control block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Offsets are byte addresses; registers hold 8 bits in the low lanes.

package serial_pkg;

  // ***************************************************************
  // Register offsets.
  // ***************************************************************
  localparam logic [7:0] FMT_OFF  = 8'h00;
  localparam logic [7:0] ENA_OFF  = 8'h04;
  localparam logic [7:0] NTH_OFF  = 8'h08;
  localparam logic [7:0] DATA_OFF = 8'h0C;
  localparam logic [7:0] STAT_OFF = 8'h10;
  localparam logic [7:0] BAUD_OFF = 8'h14;

  // ***************************************************************
  // Field positions of the format register.
  // ***************************************************************
  localparam int FMT_UNIT_ON = 6;
  localparam int FMT_INVERT  = 5;
  localparam int FMT_CHAR9   = 4;
  localparam int FMT_WAKE_MK = 3;
  localparam int FMT_IDLE_OR = 2;
  localparam int FMT_PAR_ON  = 1;
  localparam int FMT_PAR_ODD = 0;
  localparam logic [7:0] FMT_MASK = 8'h7F;

  // ***************************************************************
  // Field positions of the enable and interrupt register.
  // ***************************************************************
  localparam int ENA_TXE_IE = 7;
  localparam int ENA_TXD_IE = 6;
  localparam int ENA_RXF_IE = 5;
  localparam int ENA_IDL_IE = 4;
  localparam int ENA_TX_ON  = 3;
  localparam int ENA_RX_ON  = 2;
  localparam int ENA_STBY   = 1;
  localparam int ENA_BREAK  = 0;

  // ***************************************************************
  // Field positions of the ninth-bit register and the status register.
  // ***************************************************************
  localparam int NTH_RX9    = 7;
  localparam int NTH_TX9    = 6;
  localparam int NTH_OVR_IE = 3;
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_IDLE     = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_PAR_ERR  = 0;

  // ***************************************************************
  // Reset values and frame lengths.
  // ***************************************************************
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h0F;
  localparam logic [3:0] LEN8     = 4'hA;
  localparam logic [3:0] LEN9     = 4'hB;
  localparam logic [10:0] ALL_ONES = 11'h7FF;
  localparam logic [10:0] ALL_ZERO = 11'h000;

  typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum {RX_IDLE, RX_FRAME} rx_state_t;

endpackage

/* tb/serial_async_control_asserts.sv */
// Purpose: Port checker of the serial control block.
// Assumes: Control registers are shadowed from completed APB writes.
// Notes:   A unit switched off in mid-frame lets the pin settle two cycles later.
`timescale 1ns/100ps
module serial_async_control_asserts
  import serial_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_pin,
  input wire logic        rx_pin,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        err_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ********
  // Shadow registers.
  // ********
  logic [7:0] fmt_r;
  logic [7:0] ena_r;
  logic [7:0] nth_r;
  logic       wr_hit;
  assign wr_hit = psel && penable && pready && pwrite;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_r <= 8'h00;
      ena_r <= 8'h00;
      nth_r <= 8'h00;
    end else if (wr_hit) begin
      if (paddr == FMT_OFF) fmt_r <= pwdata[7:0] & FMT_MASK;
      if (paddr == ENA_OFF) ena_r <= pwdata[7:0];
      if (paddr == NTH_OFF) nth_r <= pwdata[7:0];
    end
  end
  ready_after_setup_a: assert property ((psel && !penable) |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_read_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  mapped_ok_a: assert property (pready && paddr <= BAUD_OFF && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  fmt_read_a: assert property (
    pready && !pwrite && paddr == FMT_OFF |-> prdata == {24'h0, fmt_r})
    else $error("format readback wrong");
  ena_read_a: assert property (
    pready && !pwrite && paddr == ENA_OFF |-> (prdata[7:0] & 8'hFD) == (ena_r & 8'hFD))
    else $error("enable readback wrong");
  tx_irq_mask_a: assert property ((ena_r[7:6] == 2'h0) [*2] |-> !tx_irq)
    else $error("tx irq without enable");
  rx_irq_mask_a: assert property ((ena_r[5:4] == 2'h0) [*2] |-> !rx_irq)
    else $error("rx irq without enable");
  err_irq_mask_a: assert property ((!nth_r[3]) [*2] |-> !err_irq)
    else $error("err irq without enable");
  tx_idle_off_a: assert property ((fmt_r[6:5] == 2'h0) [*3] |-> tx_pin)
    else $error("tx pin not idle high");
  cover property (pready && pslverr);
  cover property (rx_irq);
  cover property (err_irq);
endmodule
bind serial_async_control serial_async_control_asserts serial_async_control_asserts_i (
  .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .tx_pin, .rx_pin, .tx_irq, .rx_irq, .err_irq);

/* tb/serial_async_control_tb.sv */
// Purpose: Self-checking bench of the serial control block.
// Assumes: Baud register 3 gives four clocks a bit.
// Notes:   Line frames are driven and sampled by the line model; the bench builds and checks them.
`timescale 1ns/100ps
module serial_async_control_tb
  import serial_pkg::*;
;
  logic        mclk, arst_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, tx_pin, rx_pin, tx_irq, rx_irq, err_irq, er_q;
  logic [10:0] fr_q;
  int          miscompares = 0;
  int          check_count = 0;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  serial_async_control serial_async_control_i (.mclk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_pin, .rx_pin, .tx_irq, .rx_irq, .err_irq);
  serial_line_model #(.BT(4)) serial_line_model_i (.mclk, .tx_pin, .rx_pin);
  // ********
  // Tasks.
  // ********
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk) penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rd_q, er_q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00, rd_q, er_q);
    chk($sformatf("reg %h", a), rd_q & {24'hFFFFFF, m}, {24'h0, e});
  endtask
  task automatic txc(input logic [7:0] d, input logic inv, input int n, input logic [10:0] f);
    apb(1'b0, STAT_OFF, 8'h00, rd_q, er_q);
    wr(DATA_OFF, d);
    serial_line_model_i.recv(inv, n, fr_q);
    chk("tx frame", {21'h0, fr_q}, {21'h0, f});
  endtask
  task automatic finish_test;
    $display("check_count %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ********
  // Tests.
  // ********
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    rdc(FMT_OFF, 8'hFF, 8'h00);
    rdc(ENA_OFF, 8'hFF, 8'h00);
    rdc(NTH_OFF, 8'h08, 8'h00);
    apb(1'b0, 8'h20, 8'h00, rd_q, er_q);
    chk("unmapped err", {31'h0, er_q}, 32'h1);
    chk("unmapped data", rd_q, 32'h0);
    wr(FMT_OFF, 8'hFF);
    rdc(FMT_OFF, 8'hFF, 8'h7F);
    wr(BAUD_OFF, 8'h03);
    wr(FMT_OFF, 8'h40);
    wr(ENA_OFF, 8'h08);
    txc(8'hA5, 1'b0, 10, {2'b01, 8'hA5, 1'b0});
    wr(FMT_OFF, 8'h53);
    txc(8'h5A, 1'b0, 11, {1'b1, ~^8'h5A, 8'h5A, 1'b0});
    wr(FMT_OFF, 8'h42);
    txc(8'h07, 1'b0, 10, {2'b01, ^7'h07, 7'h07, 1'b0});
    wr(FMT_OFF, 8'h50);
    wr(NTH_OFF, 8'h40);
    txc(8'h3C, 1'b0, 11, {2'b11, 8'h3C, 1'b0});
    wr(FMT_OFF, 8'h60);
    txc(8'h0F, 1'b1, 10, {2'b01, 8'h0F, 1'b0});
    repeat (6) @(posedge mclk);
    chk("inverted idle", {31'h0, tx_pin}, 32'h0);
    wr(FMT_OFF, 8'h40);
    wr(ENA_OFF, 8'h88);
    repeat (2) @(posedge mclk);
    chk("tx irq", {31'h0, tx_irq}, 32'h1);
    wr(ENA_OFF, 8'h2C);
    serial_line_model_i.send({2'b01, 8'h81, 1'b0}, 10);
    repeat (4) @(posedge mclk);
    chk("rx irq", {31'h0, rx_irq}, 32'h1);
    apb(1'b0, STAT_OFF, 8'h00, rd_q, er_q);
    rdc(DATA_OFF, 8'hFF, 8'h81);
    rdc(NTH_OFF, 8'h80, 8'h80);
    chk("rx irq clear", {31'h0, rx_irq}, 32'h0);
    wr(NTH_OFF, 8'h08);
    serial_line_model_i.send({2'b01, 8'h11, 1'b0}, 10);
    serial_line_model_i.send({2'b01, 8'h22, 1'b0}, 10);
    repeat (4) @(posedge mclk);
    chk("err irq", {31'h0, err_irq}, 32'h1);
    wr(ENA_OFF, 8'h08);
    repeat (2) @(posedge mclk);
    chk("flags kept", {31'h0, err_irq}, 32'h1);
    apb(1'b0, STAT_OFF, 8'h00, rd_q, er_q);
    rdc(DATA_OFF, 8'hFF, 8'h11);
    wr(ENA_OFF, 8'h09);
    serial_line_model_i.recv(1'b0, 11, fr_q);
    chk("held break", {21'h0, fr_q}, 32'h0);
    wr(ENA_OFF, 8'h08);
    repeat (40) @(posedge mclk);
    chk("after break", {31'h0, tx_pin}, 32'h1);
    wr(ENA_OFF, 8'h48);
    repeat (2) @(posedge mclk);
    chk("tx done irq", {31'h0, tx_irq}, 32'h1);
    wr(FMT_OFF, 8'h00);
    repeat (2) @(posedge mclk);
    chk("unit off irq", {31'h0, tx_irq}, 32'h0);
    rdc(STAT_OFF, 8'hC0, 8'hC0);
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    finish_test;
  end
endmodule

/* tb/serial_line_model.sv */
// Purpose: Remote station that drives rx_pin and samples tx_pin.
// Assumes: Bit time is BT clocks and the line idles high.
// Notes:   Frames are held LSB first with the start bit in bit 0.
`timescale 1ns/100ps
module serial_line_model #(
  parameter int BT = 4
) (
  input  wire logic mclk,
  input  wire logic tx_pin,
  output logic      rx_pin
);
  initial rx_pin = 1'b1;
  // Sends n bits, each BT clocks, then idles high.
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) rx_pin <= f[i];
      repeat (BT - 1) @(posedge mclk);
    end
    @(posedge mclk) rx_pin <= 1'b1;
  endtask
  // Samples n bits at mid bit after a start edge.
  task automatic recv(input logic inv, input int n, output logic [10:0] f);
    f = '0;
    @(posedge mclk iff (tx_pin ^ inv) === 1'b0);
    repeat (BT / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      f[i] = tx_pin ^ inv;
      repeat (BT) @(posedge mclk);
    end
  endtask
endmodule
